//--- link_host.sv
// Host model: 2-wire bus master
`timescale 1ns/100ps
`default_nettype none
module link_host
   import optmod_pkg::*;
(
   // 2-wire bus
   output logic scl,
   output logic sda_m,
   input wire logic sda_line
);
   // Idle: clock high, data released
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   // Odd 3 ns keeps edges off the core clock
   task automatic start();
      #3 sda_m = 1'b1;
      #16 scl = 1'b1;
      #16 sda_m = 1'b0;
      #16 scl = 1'b0;
      #16;
   endtask
   task automatic stop();
      sda_m = 1'b0;
      #16 scl = 1'b1;
      #16 sda_m = 1'b1;
      #16;
   endtask
   // MSB first, then acknowledge; sampled late in high phase
   task automatic xbyte(input byte_t d, input logic ak_in, output byte_t q, output logic ak);
      logic [8:0] v;
      v = {d, ak_in};
      for (int i = 8; i >= 0; i--) begin
         sda_m = v[i];
         #16 scl = 1'b1;
         #32 v[i] = sda_line;
         scl = 1'b0;
         #16;
      end
      q = v[8:1];
      ak = v[0];
   endtask
endmodule
`default_nettype wire

//--- optical_module_mgmt_ctrl.sv
// Optical module management and control logic
// How it works
// - Transmit fault high when monitors are flagged valid and bias or transmit power exceeds alarm thresholds.
// - Laser off while transmit-disable is high or open; on only when low.
// - Loss-of-signal output is 1 when optical input lost, 0 otherwise.
// - Presence pin is tied low so host sees module plugged in.
// - Memory is one 128-byte lower page with flags, monitors, plus upper pages.
// - Page select byte maps chosen upper page into upper address half.
// - Multi-lane end answers at A0h; flags readable in one read pass.
// - Host reads flag byte after interrupt to find lane and flag kind.
// - Single-lane diagnostic memory answers at 1010001X, apart from ID contents.
// - Diagnostic memory: 56 threshold, 40 calibration, 24 real-time bytes, then more.
// - 120 bytes of user storage the host writes and reads back.
// - Measured power, bias, supply, temperature published as calibrated values.
// - Serial interface ready within 2000 ms after power-up.
// - Monitor data valid within 2000 ms after power-up.
// - A reset pin low for 2 us or more is taken as a reset.
// - Transmit fault asserted within 200 ms of the fault condition.
// - Reduced power entered within 100 ms of power override or set.
// - Full power resumed within 300 ms of clearing the power control.
`timescale 1ns/100ps
`default_nettype none
`include "optmod_params.svh"

module optical_module_mgmt_ctrl
   import optmod_pkg::*;
#(
   parameter logic [31:0] INIT_CYCLES = 32'(`INIT_MAX_CYC)
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // AHB-Lite register slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Host control pins
   input wire logic module_select_n,
   input wire logic module_reset_n,
   input wire logic low_power_request,
   input wire logic tx_disable,
   input wire logic [3:0] rx_signal_present,
   // 2-wire serial bus
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Status pins
   output logic module_irq_n,
   output logic present_n,
   output logic absent_indication,
   output logic tx_fault,
   output logic [3:0] rx_los,
   output logic laser_enable,
   output logic low_power_state
);

   localparam int unsigned NA = 10;

   function automatic logic [2:0] reg_sel(input logic [31:0] a);
      case (a[7:0])
         `REG_CTRL: reg_sel = 3'h1;
         `REG_MON_TV: reg_sel = 3'h2;
         `REG_MON_BT: reg_sel = 3'h3;
         `REG_MON_RX: reg_sel = 3'h4;
         `REG_MEM_WIN: reg_sel = 3'h5;
         `REG_STATUS: reg_sel = 3'h6;
         default: reg_sel = 3'h0;
      endcase
      if (a[31:8] != 24'h00_0000) begin
         reg_sel = 3'h0;
      end
   endfunction

   function automatic logic [9:0] mem_index(input logic diag, input byte_t a, input logic pg);
      if (diag) begin
         mem_index = `DIAG_BASE + {2'b00, a};
      end else if (a[7]) begin
         mem_index = `UPPER_BASE + {2'b00, pg, a[6:0]};
      end else begin
         mem_index = {3'b000, a[6:0]};
      end
   endfunction

   // Input synchronisers
   logic [NA-1:0] async_in, sync1_q, sync2_q;
   assign async_in = {module_select_n, module_reset_n, low_power_request, tx_disable,
                      rx_signal_present, scl_i, sda_i};
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sync1_q <= 10'h3ff;
         sync2_q <= 10'h3ff;
      end else begin
         sync1_q <= async_in;
         sync2_q <= sync1_q;
      end
   end

   logic sel_n_s, rst_n_s, lpreq_s, txdis_s, scl_s, sda_s;
   logic [3:0] sigp_s;
   assign {sel_n_s, rst_n_s, lpreq_s, txdis_s, sigp_s, scl_s, sda_s} = sync2_q;

   // Management memory and live state
   byte_t mem_q [0:`MEM_BYTES-1];
   logic [31:0] ctrl_q;
   logic [15:0] temp_q, vcc_q, bias_q, txp_q, rxp_q;
   logic [9:0] win_addr_q;
   logic [3:0] los_flag_q, los_prev_q;
   logic txf_flag_q, txf_prev_q, flag_clr;
   logic mod_rst_q, ready_q;
   logic [15:0] rst_cnt_q;
   logic [31:0] init_cnt_q;
   logic s_wr_q;
   logic [9:0] s_wr_idx_q;
   byte_t s_wr_dat_q;
   logic fault_now;

   // Host reset filter: short lows ignored
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rst_cnt_q <= 16'h0000;
         mod_rst_q <= 1'b0;
      end else if (rst_n_s) begin
         rst_cnt_q <= 16'h0000;
         mod_rst_q <= 1'b0;
      end else if (rst_cnt_q >= 16'(`RESET_MIN_CYC - 1)) begin
         mod_rst_q <= 1'b1;
      end else begin
         rst_cnt_q <= rst_cnt_q + 16'h0001;
      end
   end

   // Init timer gates serial access and monitor data
   always_ff @(posedge core_clk) begin
      if (sys_rst || mod_rst_q) begin
         init_cnt_q <= 32'h0000_0000;
         ready_q <= 1'b0;
      end else if (init_cnt_q >= INIT_CYCLES - 32'h1) begin
         ready_q <= 1'b1;
      end else begin
         init_cnt_q <= init_cnt_q + 32'h1;
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY
   logic dp_wr_q;
   logic [2:0] dp_sel_q;
   logic ap_take;
   logic [31:0] status_word;
   assign ap_take = hsel && hready && htrans[1];
   assign status_word = {22'h00_0000, low_power_state, laser_enable, tx_fault, txf_flag_q,
                         los_flag_q, ready_q, mod_rst_q};

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         dp_wr_q <= 1'b0;
         dp_sel_q <= 3'h0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dp_wr_q <= ap_take && hwrite;
         dp_sel_q <= ap_take ? reg_sel(haddr) : 3'h0;
         if (ap_take && !hwrite) begin
            case (reg_sel(haddr))
               3'h1: hrdata <= ctrl_q;
               3'h2: hrdata <= {temp_q, vcc_q};
               3'h3: hrdata <= {bias_q, txp_q};
               3'h4: hrdata <= {16'h0000, rxp_q};
               3'h5: hrdata <= {6'h00, win_addr_q, 8'h00, mem_q[win_addr_q]};
               3'h6: hrdata <= status_word;
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Software loads measurements; values are already calibrated
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ctrl_q <= `CTRL_RESET;
         temp_q <= `MON_RESET;
         vcc_q <= `MON_RESET;
         bias_q <= `MON_RESET;
         txp_q <= `MON_RESET;
         rxp_q <= `MON_RESET;
         win_addr_q <= 10'h000;
      end else if (dp_wr_q) begin
         case (dp_sel_q)
            3'h1: ctrl_q <= {31'h0, hwdata[`CTRL_MON_VALID]};
            3'h2: {temp_q, vcc_q} <= hwdata;
            3'h3: {bias_q, txp_q} <= hwdata;
            3'h4: rxp_q <= hwdata[15:0];
            3'h5: win_addr_q <= hwdata[`WIN_ADDR_LSB +: 10];
            default: ;
         endcase
      end
   end

   // Memory writes: serial bus wins a same-cycle collision with the window
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < `MEM_BYTES; i++) begin
            mem_q[i] <= 8'h00;
         end
      end else if (mod_rst_q) begin
         mem_q[`LP_PAGE_SEL] <= 8'h00;
         mem_q[`LP_POWER_CTL] <= 8'h00;
      end else if (s_wr_q) begin
         mem_q[s_wr_idx_q] <= s_wr_dat_q;
      end else if (dp_wr_q && dp_sel_q == 3'h5 && hwdata[`WIN_ADDR_LSB +: 10] < 10'(`MEM_BYTES)) begin
         mem_q[hwdata[`WIN_ADDR_LSB +: 10]] <= hwdata[7:0];
      end
   end

   // Fault detection against alarm thresholds in diagnostic memory
   logic [15:0] bias_thr, txp_thr;
   assign bias_thr = {mem_q[`DIAG_BASE + `DG_BIAS_HI_ALARM], mem_q[`DIAG_BASE + `DG_BIAS_HI_ALARM + 1]};
   assign txp_thr = {mem_q[`DIAG_BASE + `DG_TXP_HI_ALARM], mem_q[`DIAG_BASE + `DG_TXP_HI_ALARM + 1]};
   assign fault_now = ctrl_q[`CTRL_MON_VALID] && ((bias_q > bias_thr) || (txp_q > txp_thr));

   // Sticky flags: set on a rising condition; a set beats a read-clear
   always_ff @(posedge core_clk) begin
      if (sys_rst || mod_rst_q) begin
         los_flag_q <= 4'h0;
         los_prev_q <= 4'h0;
         txf_flag_q <= 1'b0;
         txf_prev_q <= 1'b0;
      end else begin
         los_prev_q <= ~sigp_s;
         txf_prev_q <= fault_now;
         los_flag_q <= (flag_clr ? 4'h0 : los_flag_q) | (~sigp_s & ~los_prev_q);
         txf_flag_q <= (flag_clr ? 1'b0 : txf_flag_q) | (fault_now & ~txf_prev_q);
      end
   end

   // Pin outputs
   logic pwr_low;
   byte_t pwr_ctl;
   assign pwr_ctl = mem_q[`LP_POWER_CTL];
   assign pwr_low = pwr_ctl[`PWR_OVERRIDE] ? pwr_ctl[`PWR_SET] : lpreq_s;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         module_irq_n <= 1'b1;
         present_n <= 1'b0;
         absent_indication <= 1'b0;
         tx_fault <= 1'b0;
         rx_los <= 4'h0;
         laser_enable <= 1'b0;
         low_power_state <= 1'b1;
      end else begin
         module_irq_n <= ~(|({3'h0, txf_flag_q, los_flag_q} & ~mem_q[`LP_MASK]));
         present_n <= 1'b0;
         absent_indication <= 1'b0;
         tx_fault <= fault_now;
         rx_los <= ~sigp_s;
         // Laser also dark in low power or module reset
         laser_enable <= ~txdis_s && !pwr_low && !mod_rst_q;
         low_power_state <= pwr_low || mod_rst_q;
      end
   end

   // Serial slave: edges found from synchronised copies
   logic scl_d_q, sda_d_q;
   logic scl_rise, scl_fall, ser_start, ser_stop;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         scl_d_q <= 1'b1;
         sda_d_q <= 1'b1;
      end else begin
         scl_d_q <= scl_s;
         sda_d_q <= sda_s;
      end
   end
   assign scl_rise = scl_s && !scl_d_q;
   assign scl_fall = !scl_s && scl_d_q;
   assign ser_start = scl_s && scl_d_q && sda_d_q && !sda_s;
   assign ser_stop = scl_s && scl_d_q && !sda_d_q && sda_s;

   ser_state_t st_q;
   logic [3:0] cnt_q;
   byte_t shift_q, ptr_q, rd_byte, out_q;
   logic diag_q, rw_q, first_q, mack_q;
   logic [9:0] rd_idx;
   logic addr_hit, wr_ok;

   // Multi-lane end answers only while selected; diagnostic end whatever the select (both need ready, no reset)
   assign addr_hit = ready_q && !mod_rst_q && ((shift_q[7:1] == `DEV_MULTI && !sel_n_s)
                     || shift_q[7:1] == `DEV_DIAG);
   assign rd_idx = mem_index(diag_q, ptr_q, mem_q[`LP_PAGE_SEL][0]);
   assign wr_ok = diag_q ? (ptr_q >= `DG_USER_FIRST && ptr_q <= `DG_USER_LAST)
                 : (ptr_q >= `LP_WR_FIRST && ptr_q <= `LP_PAGE_SEL);
   assign flag_clr = scl_fall && !diag_q && ptr_q == `LP_FLAGS
                     && ((st_q == SER_AACK && rw_q) || (st_q == SER_RACK && mack_q));

   // Live values overlay stored bytes
   always_comb begin
      rd_byte = mem_q[rd_idx];
      if (!diag_q) begin
         case (ptr_q)
            `LP_STATUS: rd_byte = {7'h00, !(ready_q && ctrl_q[`CTRL_MON_VALID])};
            `LP_FLAGS: rd_byte = {3'h0, txf_flag_q, los_flag_q};
            `LP_TEMP: rd_byte = temp_q[15:8];
            `LP_TEMP + 8'h01: rd_byte = temp_q[7:0];
            `LP_VCC: rd_byte = vcc_q[15:8];
            `LP_VCC + 8'h01: rd_byte = vcc_q[7:0];
            default: ;
         endcase
      end else begin
         case (ptr_q)
            `DG_RT_FIRST: rd_byte = temp_q[15:8];
            `DG_RT_FIRST + 8'h01: rd_byte = temp_q[7:0];
            `DG_RT_FIRST + 8'h02: rd_byte = vcc_q[15:8];
            `DG_RT_FIRST + 8'h03: rd_byte = vcc_q[7:0];
            `DG_RT_FIRST + 8'h04: rd_byte = bias_q[15:8];
            `DG_RT_FIRST + 8'h05: rd_byte = bias_q[7:0];
            `DG_RT_FIRST + 8'h06: rd_byte = txp_q[15:8];
            `DG_RT_FIRST + 8'h07: rd_byte = txp_q[7:0];
            `DG_RT_FIRST + 8'h08: rd_byte = rxp_q[15:8];
            `DG_RT_FIRST + 8'h09: rd_byte = rxp_q[7:0];
            `DG_STATUS: rd_byte = {txdis_s, 4'h0, tx_fault, ~sigp_s[0], !(ready_q && ctrl_q[`CTRL_MON_VALID])};
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst || mod_rst_q) begin
         st_q <= SER_IDLE;
         cnt_q <= 4'h0;
         shift_q <= 8'h00;
         out_q <= 8'h00;
         ptr_q <= 8'h00;
         diag_q <= 1'b0;
         rw_q <= 1'b0;
         first_q <= 1'b0;
         mack_q <= 1'b0;
         sda_oe <= 1'b0;
         sda_o <= 1'b0;
         s_wr_q <= 1'b0;
         s_wr_idx_q <= 10'h000;
         s_wr_dat_q <= 8'h00;
      end else begin
         sda_o <= 1'b0;
         s_wr_q <= 1'b0;
         if (ser_start) begin
            st_q <= SER_ADDR;
            cnt_q <= 4'h0;
            sda_oe <= 1'b0;
         end else if (ser_stop) begin
            st_q <= SER_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            if (st_q == SER_ADDR || st_q == SER_WDATA) begin
               shift_q <= {shift_q[6:0], sda_s};
               cnt_q <= cnt_q + 4'h1;
            end else if (st_q == SER_RACK) begin
               mack_q <= !sda_s;
            end
         end else if (scl_fall) begin
            case (st_q)
               SER_ADDR: begin
                  if (cnt_q == 4'h8) begin
                     if (addr_hit) begin
                        st_q <= SER_AACK;
                        sda_oe <= 1'b1;
                        diag_q <= shift_q[1];
                        rw_q <= shift_q[0];
                        first_q <= 1'b1;
                     end else begin
                        st_q <= SER_IDLE;
                     end
                  end
               end
               SER_AACK: begin
                  cnt_q <= 4'h0;
                  if (rw_q) begin
                     st_q <= SER_RDATA;
                     out_q <= {rd_byte[6:0], 1'b0};
                     sda_oe <= !rd_byte[7];
                     ptr_q <= ptr_q + 8'h01;
                  end else begin
                     st_q <= SER_WDATA;
                     sda_oe <= 1'b0;
                  end
               end
               SER_WDATA: begin
                  if (cnt_q == 4'h8) begin
                     st_q <= SER_WACK;
                     sda_oe <= 1'b1;
                     first_q <= 1'b0;
                     if (first_q) begin
                        ptr_q <= shift_q;
                     end else begin
                        s_wr_q <= wr_ok;
                        s_wr_idx_q <= rd_idx;
                        s_wr_dat_q <= shift_q;
                        ptr_q <= ptr_q + 8'h01;
                     end
                  end
               end
               SER_WACK: begin
                  st_q <= SER_WDATA;
                  cnt_q <= 4'h0;
                  sda_oe <= 1'b0;
               end
               SER_RDATA: begin
                  if (cnt_q == 4'h7) begin
                     st_q <= SER_RACK;
                     sda_oe <= 1'b0;
                     mack_q <= 1'b0;
                  end else begin
                     sda_oe <= !out_q[7];
                     out_q <= {out_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
               SER_RACK: begin
                  if (mack_q) begin
                     st_q <= SER_RDATA;
                     cnt_q <= 4'h0;
                     out_q <= {rd_byte[6:0], 1'b0};
                     sda_oe <= !rd_byte[7];
                     ptr_q <= ptr_q + 8'h01;
                  end else begin
                     st_q <= SER_IDLE;
                  end
               end
               default: st_q <= SER_IDLE;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

//--- optmod_mgmt_asserts.sv
// Port assertions of the optical module controller
`timescale 1ns/100ps
`default_nettype none
module optmod_mgmt_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Bus answer
   input wire logic hreadyout,
   input wire logic hresp,
   // Host pins
   input wire logic module_reset_n,
   input wire logic low_power_request,
   input wire logic tx_disable,
   input wire logic [3:0] rx_signal_present,
   input wire logic scl_i,
   // Module outputs
   input wire logic sda_oe,
   input wire logic module_irq_n,
   input wire logic present_n,
   input wire logic absent_indication,
   input wire logic tx_fault,
   input wire logic [3:0] rx_los,
   input wire logic laser_enable,
   input wire logic low_power_state
);
   logic [8:0] rst_low_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // Saturating host reset low time
   always_ff @(posedge core_clk) begin
      if (sys_rst || module_reset_n) begin
         rst_low_q <= 9'h000;
      end else if (rst_low_q != 9'h1ff) begin
         rst_low_q <= rst_low_q + 9'h001;
      end
   end
   AST_PRESENT_LOW: assert property (present_n == 1'b0 && absent_indication == 1'b0)
      else $error("presence pins high");
   AST_LASER_OFF: assert property (tx_disable [*6] |-> !laser_enable)
      else $error("laser on while disabled");
   AST_LOW_POWER: assert property (low_power_request [*6] |-> low_power_state && !laser_enable)
      else $error("low power ignored");
   AST_RX_LOS: assert property ($stable(rx_signal_present) [*8] |-> rx_los == ~rx_signal_present)
      else $error("loss of signal wrong");
   AST_RESET_EXIT: assert property ($fell(sys_rst) |->
      low_power_state && !laser_enable && !tx_fault && module_irq_n && !sda_oe)
      else $error("outputs busy after reset");
   AST_HOST_RESET: assert property (rst_low_q >= 9'h10e |->
      low_power_state && !laser_enable && !sda_oe && module_irq_n)
      else $error("host reset not taken");
   // Data moves only while clock low
   AST_SDA_HOLD: assert property (scl_i && $past(scl_i) && $past(scl_i, 2) |-> $stable(sda_oe))
      else $error("data moved with clock high");
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus stall or error");
endmodule
bind optical_module_mgmt_ctrl optmod_mgmt_asserts optmod_mgmt_asserts_i (
   .core_clk, .sys_rst, .hreadyout, .hresp, .module_reset_n, .low_power_request, .tx_disable,
   .rx_signal_present, .scl_i, .sda_oe, .module_irq_n, .present_n, .absent_indication, .tx_fault,
   .rx_los, .laser_enable, .low_power_state
);
`default_nettype wire

//--- optmod_params.svh
// Constants of the optical module controller
`ifndef OPTMOD_PARAMS_SVH
`define OPTMOD_PARAMS_SVH

// Core clock
`define CLK_PERIOD_NS 8
// Host reset pulse least width
`define T_RESET_MIN_NS 2000
`define RESET_MIN_CYC ((`T_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Serial and monitor ready time, longest
`define T_INIT_MAX_MS 2000
`define INIT_MAX_CYC ((`T_INIT_MAX_MS * 1000000) / `CLK_PERIOD_NS)

// Register bus byte offsets
`define REG_CTRL 8'h00
`define REG_MON_TV 8'h04
`define REG_MON_BT 8'h08
`define REG_MON_RX 8'h0c
`define REG_MEM_WIN 8'h10
`define REG_STATUS 8'h14
// Control fields
`define CTRL_MON_VALID 0
`define WIN_ADDR_LSB 16
// Reset values
`define CTRL_RESET 32'h0000_0000
`define MON_RESET 16'h0000

// Serial device addresses
`define DEV_MULTI 7'h50
`define DEV_DIAG 7'h51
// Management memory layout
`define PAGE_BYTES 128
`define MEM_BYTES 640
`define UPPER_BASE 10'h080
`define DIAG_BASE 10'h180
// Lower page locations
`define LP_STATUS 8'h02
`define LP_FLAGS 8'h03
`define LP_TEMP 8'h16
`define LP_VCC 8'h1a
`define LP_WR_FIRST 8'h56
`define LP_POWER_CTL 8'h5d
`define LP_MASK 8'h64
`define LP_PAGE_SEL 8'h7f
`define PWR_OVERRIDE 0
`define PWR_SET 1
// Diagnostic memory locations
`define DG_BIAS_HI_ALARM 8'h10
`define DG_TXP_HI_ALARM 8'h18
`define DG_RT_FIRST 8'h60
`define DG_STATUS 8'h6e
`define DG_USER_FIRST 8'h80
`define DG_USER_LAST 8'hf7

`endif

//--- optmod_pkg.sv
// Optical module controller types
package optmod_pkg;
   typedef enum logic [2:0] {
      SER_IDLE = 3'b000,
      SER_ADDR = 3'b001,
      SER_AACK = 3'b010,
      SER_WDATA = 3'b011,
      SER_WACK = 3'b100,
      SER_RDATA = 3'b101,
      SER_RACK = 3'b110
   } ser_state_t;
   typedef logic [7:0] byte_t;
endpackage

//--- tb_top.sv
// Testbench of the optical module controller
`timescale 1ns/100ps
`default_nettype none
`include "optmod_params.svh"
module tb_top;
   import optmod_pkg::*;
   typedef struct {logic [31:0] a, d, r; logic f;} row_t;
   logic core_clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic module_select_n = 1'b1, module_reset_n = 1'b1, low_power_request = 1'b1, tx_disable = 1'b1;
   logic [3:0] rx_signal_present = 4'hf, rx_los;
   logic hreadyout, hresp, scl, sda_m, sda_oe, module_irq_n, present_n, absent_indication;
   logic tx_fault, laser_enable, low_power_state;
   wire logic sda_w;
   wire logic [31:0] pv;
   int fails = 0, tests_run = 0;
   // Open drain, pulled up
   assign sda_w = sda_m & ~sda_oe;
   assign pv = {25'h0, module_irq_n, low_power_state, laser_enable, rx_los};
   row_t rows [14] = '{
      '{32'h10, 32'h0190_0001, 32'h0190_0001, 1'b0},
      '{32'h10, 32'h0191_0000, 32'h0191_0000, 1'b0},
      '{32'h10, 32'h0198_0003, 32'h0198_0003, 1'b0},
      '{32'h10, 32'h0199_0000, 32'h0199_0000, 1'b0},
      '{32'h08, 32'h0101_0300, 32'h0101_0300, 1'b0},
      '{32'h00, 32'h1, 32'h1, 1'b1},
      '{32'h08, 32'h0100_0300, 32'h0100_0300, 1'b0},
      '{32'h08, 32'h0100_0301, 32'h0100_0301, 1'b1},
      '{32'h04, 32'h1234_5678, 32'h1234_5678, 1'b1},
      '{32'h0c, 32'habcd_1357, 32'h0000_1357, 1'b1},
      '{32'h18, 32'hffff_ffff, 32'h0, 1'b1},
      '{32'h100, 32'h0, 32'h0, 1'b1},
      '{32'h08, 32'h0, 32'h0, 1'b0},
      '{32'h10, 32'h0200_005a, 32'h0200_005a, 1'b0}
   };
   optical_module_mgmt_ctrl #(.INIT_CYCLES(32'h10)) optical_module_mgmt_ctrl_i (
      .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .module_select_n, .module_reset_n, .low_power_request, .tx_disable,
      .rx_signal_present, .scl_i(scl), .sda_i(sda_w), .sda_o(), .sda_oe, .module_irq_n, .present_n,
      .absent_indication, .tx_fault, .rx_los, .laser_enable, .low_power_state
   );
   link_host link_host_i (.scl, .sda_m, .sda_line(sda_w));
   always #4 core_clk = ~core_clk;
   task automatic chk(input string nm, input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic results();
      $display("Checks %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      int n = 0;
      @(posedge core_clk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      htrans <= 2'b00;
      hwdata <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      r = hrdata;
      if (n >= 40) begin
         fails++;
         results();
      end
   endtask
   task automatic mw(input logic [9:0] i, input byte_t b);
      ahb(1'b1, {24'h0, `REG_MEM_WIN}, {6'h00, i, 8'h00, b}, q);
   endtask
   task automatic settle();
      repeat (8) @(posedge core_clk);
      #1;
   endtask
   // Bit 8 high: address not acknowledged
   task automatic srd(input logic [6:0] dev, input byte_t ptr, output logic [31:0] r);
      byte_t z, d;
      logic a0, a1, a2;
      link_host_i.start();
      link_host_i.xbyte({dev, 1'b0}, 1'b1, z, a0);
      link_host_i.xbyte(ptr, 1'b1, z, a1);
      link_host_i.start();
      link_host_i.xbyte({dev, 1'b1}, 1'b1, z, a2);
      link_host_i.xbyte(8'hff, 1'b1, d, a1);
      link_host_i.stop();
      r = {23'h0, a0 | a2, d};
   endtask
   task automatic swr(input logic [6:0] dev, input byte_t ptr, dat, output logic [31:0] r);
      byte_t z;
      logic a0, a1, a2;
      link_host_i.start();
      link_host_i.xbyte({dev, 1'b0}, 1'b1, z, a0);
      link_host_i.xbyte(ptr, 1'b1, z, a1);
      link_host_i.xbyte(dat, 1'b1, z, a2);
      link_host_i.stop();
      r = {31'h0, a0 | a1 | a2};
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      #1;
      chk("reset pins", pv, 32'h60);
      chk("presence", {30'h0, present_n, absent_indication}, 32'h0);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         ahb(1'b0, 32'(4 * i), 32'h0, q);
         chk("reset value", q, 32'h0);
      end
      foreach (rows[i]) begin
         ahb(1'b1, rows[i].a, rows[i].d, q);
         ahb(1'b0, rows[i].a, 32'h0, q);
         settle();
         chk("register", q, rows[i].r);
         chk("tx_fault", {31'h0, tx_fault}, {31'h0, rows[i].f});
      end
      chk("pins", pv, 32'h20);
      @(posedge core_clk);
      low_power_request <= 1'b0;
      settle();
      chk("pins", pv, 32'h00);
      @(posedge core_clk);
      tx_disable <= 1'b0;
      module_select_n <= 1'b0;
      settle();
      chk("pins", pv, 32'h10);
      swr(`DEV_MULTI, `LP_POWER_CTL, 8'h03, q);
      settle();
      chk("power down", {24'h0, q[0], pv[6:0]}, 32'h20);
      swr(`DEV_MULTI, `LP_POWER_CTL, 8'h00, q);
      settle();
      chk("power up", {24'h0, q[0], pv[6:0]}, 32'h10);
      @(posedge core_clk);
      rx_signal_present <= 4'hb;
      settle();
      chk("lane lost", pv, 32'h14);
      srd(`DEV_MULTI, `LP_FLAGS, q);
      chk("flags", q, 32'h014);
      settle();
      chk("irq released", pv, 32'h54);
      srd(`DEV_MULTI, `LP_FLAGS, q);
      chk("flags cleared", q, 32'h000);
      swr(`DEV_MULTI, `LP_MASK, 8'h01, q);
      @(posedge core_clk);
      rx_signal_present <= 4'ha;
      settle();
      chk("masked lane", {24'h0, q[0], pv[6:0]}, 32'h55);
      @(posedge core_clk);
      module_select_n <= 1'b1;
      settle();
      srd(`DEV_MULTI, `LP_FLAGS, q);
      chk("deselected", q, 32'h1ff);
      @(posedge core_clk);
      module_select_n <= 1'b0;
      srd(`DEV_DIAG, `DG_USER_FIRST, q);
      chk("user byte", q, 32'h05a);
      swr(`DEV_DIAG, `DG_USER_LAST, 8'ha5, q);
      srd(`DEV_DIAG, `DG_USER_LAST, q);
      chk("user write", q, 32'h0a5);
      srd(`DEV_DIAG, `DG_RT_FIRST, q);
      chk("live temp", q, 32'h012);
      srd(`DEV_MULTI, `LP_TEMP, q);
      chk("lower temp", q, 32'h012);
      mw(10'h100, 8'h3c);
      mw(10'h080, 8'hc3);
      swr(`DEV_MULTI, `LP_PAGE_SEL, 8'h01, q);
      srd(`DEV_MULTI, 8'h80, q);
      chk("upper page", q, 32'h03c);
      @(posedge core_clk);
      rx_signal_present <= 4'hf;
      module_reset_n <= 1'b0;
      repeat (100) @(posedge core_clk);
      module_reset_n <= 1'b1;
      settle();
      chk("short pulse", pv, 32'h50);
      srd(`DEV_MULTI, 8'h80, q);
      chk("page kept", q, 32'h03c);
      @(posedge core_clk);
      module_reset_n <= 1'b0;
      repeat (300) @(posedge core_clk);
      #1;
      chk("long pulse", pv, 32'h60);
      ahb(1'b0, {24'h0, `REG_STATUS}, 32'h0, q);
      chk("status", {31'h0, q[0]}, 32'h1);
      @(posedge core_clk);
      module_reset_n <= 1'b1;
      repeat (40) @(posedge core_clk);
      srd(`DEV_MULTI, 8'h80, q);
      chk("page cleared", q, 32'h0c3);
      results();
   end
endmodule
`default_nettype wire
